// *** rtl/icp_defs.svh ***
// Purpose: constants of the I2C configuration command port
// Assumes: 100 MHz core clock
// Notes: counts are in core clock cycles
`ifndef ICP_DEFS_SVH
`define ICP_DEFS_SVH
`define ICP_SLAVE_ADDR 7'h6A
`define ICP_CMD_WRITE 2'h0
`define ICP_CMD_SAVE 2'h1
`define ICP_CMD_RESTORE 2'h2
`define ICP_ID_BYTE 8'h5A
`define ICP_NV_CYCLES_PER_REG 16'h0004
`endif

// *** rtl/icp_pkg.sv ***
// Purpose: types of the I2C configuration command port
// Assumes: none
// Notes: state encodings are binary
package icp_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ACK = 4'h2,
		ST_RX = 4'h3,
		ST_TX = 4'h4,
		ST_TXACK = 4'h5,
		ST_SKIP = 4'h6,
		ST_NV = 4'h7
	} icp_state_type;
	typedef enum logic [1:0] {
		PH_CMD = 2'h0,
		PH_REG = 2'h1,
		PH_DATA = 2'h2
	} icp_phase_type;
	typedef struct packed {
		logic scl;
		logic sda;
	} icp_pins_type;
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} icp_bus_ev_type;
endpackage

// *** rtl/icp_sync.sv ***
// Purpose: two-flop sampling of the I2C pins and edge detection
// Assumes: pins are asynchronous to i_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`include "icp_defs.svh"
module icp_sync
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire icp_pkg::icp_pins_type i_pins,
	output icp_pkg::icp_bus_ev_type o_ev
);
	typedef struct packed {
		icp_pkg::icp_pins_type s1;
		icp_pkg::icp_pins_type s2;
		icp_pkg::icp_pins_type s3;
	} icp_sync_st_type;
	icp_sync_st_type st_reg;
	icp_sync_st_type st_next;
	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = i_pins;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
	end
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			st_reg <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
		else
			st_reg <= st_next;
	end
	assign o_ev.scl_rise = st_reg.s2.scl & ~st_reg.s3.scl;
	assign o_ev.scl_fall = ~st_reg.s2.scl & st_reg.s3.scl;
	assign o_ev.start = st_reg.s2.scl & st_reg.s3.scl & ~st_reg.s2.sda & st_reg.s3.sda;
	assign o_ev.stop = st_reg.s2.scl & st_reg.s3.scl & st_reg.s2.sda & ~st_reg.s3.sda;
	assign o_ev.sda = st_reg.s2.sda;
endmodule

// *** rtl/icp_top.sv ***
// Purpose: I2C slave that decodes write, read, save and restore commands
// Assumes: SCL and SDA sampled by i_clk, far faster than the bus
// Notes: nonvolatile store is a flop array; copy time per register is a count
// Function
// - Read returns identity byte then register bytes
// - Write command stores data into registers
// - Command low bits 01 save registers
// - Command low bits 10 restore registers
// - Clock outputs off during restore
// - Register address increments per written byte
// - Save/restore after stop; no acks meanwhile
// - Restore automatically after reset
`timescale 1ns/1ps
`include "icp_defs.svh"
module icp_top
#(
	parameter int NREGS = 128,
	parameter logic [7:0] ID_BYTE = `ICP_ID_BYTE
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic o_outputs_off,
	output logic o_busy,
	output logic [NREGS*8-1:0] o_cfg
);
	// Identity byte value is arbitrary
	localparam int AW = $clog2(NREGS);
	// Pointer wraps by bit width, so only powers of two are served
	if (NREGS < 2 || NREGS > 256 || NREGS != (1 << AW))
	begin : g_bad_nregs
		$error("NREGS must be a power of two from 2 to 256");
	end
	typedef struct packed {
		icp_pkg::icp_state_type state;
		icp_pkg::icp_phase_type phase;
		logic [7:0] shift;
		logic [3:0] bitcnt;
		logic rnw;
		logic [1:0] cmd;
		logic [AW-1:0] ptr;
		logic [1:0] nv_op;
		logic [AW-1:0] nv_idx;
		logic [15:0] nv_cnt;
		logic sda_oe;
		logic first_rd;
		logic restoring;
		logic [NREGS*8-1:0] cfg;
		logic [NREGS*8-1:0] nv;
	} icp_st_type;
	icp_st_type st_reg;
	icp_st_type st_next;
	icp_pkg::icp_bus_ev_type ev;
	icp_pkg::icp_pins_type pins;
	assign pins.scl = i_scl;
	assign pins.sda = i_sda;
	icp_sync u_sync
	(
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_pins(pins),
		.o_ev(ev)
	);
	always_comb
	begin
		st_next = st_reg;
		if (st_reg.state == icp_pkg::ST_NV)
		begin
			// Bus ignored entirely while copying, so no ack appears
			if (st_reg.nv_cnt != 16'h0000)
				st_next.nv_cnt = st_reg.nv_cnt - 16'h0001;
			else
			begin
				st_next.nv_cnt = `ICP_NV_CYCLES_PER_REG;
				if (st_reg.nv_op == `ICP_CMD_SAVE)
					st_next.nv[st_reg.nv_idx*8 +: 8] = st_reg.cfg[st_reg.nv_idx*8 +: 8];
				else
					st_next.cfg[st_reg.nv_idx*8 +: 8] = st_reg.nv[st_reg.nv_idx*8 +: 8];
				if (st_reg.nv_idx == AW'(NREGS - 1))
				begin
					st_next.state = icp_pkg::ST_IDLE;
					st_next.nv_idx = '0;
					st_next.restoring = 1'b0;
				end
				else
					st_next.nv_idx = st_reg.nv_idx + AW'(1);
			end
		end
		else if (ev.stop)
		begin
			st_next.sda_oe = 1'b0;
			st_next.state = icp_pkg::ST_IDLE;
			// A save or restore command begins only on stop
			if (st_reg.phase == icp_pkg::PH_REG && !st_reg.rnw
				&& (st_reg.cmd == `ICP_CMD_SAVE || st_reg.cmd == `ICP_CMD_RESTORE))
			begin
				st_next.state = icp_pkg::ST_NV;
				st_next.nv_op = st_reg.cmd;
				st_next.nv_idx = '0;
				st_next.nv_cnt = `ICP_NV_CYCLES_PER_REG;
				st_next.restoring = (st_reg.cmd == `ICP_CMD_RESTORE);
			end
			st_next.phase = icp_pkg::PH_CMD;
		end
		else if (ev.start)
		begin
			st_next.state = icp_pkg::ST_ADDR;
			st_next.bitcnt = 4'h0;
			st_next.sda_oe = 1'b0;
			st_next.phase = icp_pkg::PH_CMD;
		end
		else
		begin
			case (st_reg.state)
				icp_pkg::ST_ADDR, icp_pkg::ST_RX:
				begin
					if (ev.scl_rise)
					begin
						st_next.shift = {st_reg.shift[6:0], ev.sda};
						st_next.bitcnt = st_reg.bitcnt + 4'h1;
					end
					if (ev.scl_fall && st_reg.bitcnt == 4'h8)
					begin
						st_next.bitcnt = 4'h0;
						if (st_reg.state == icp_pkg::ST_ADDR)
						begin
							if (st_reg.shift[7:1] == `ICP_SLAVE_ADDR)
							begin
								st_next.rnw = st_reg.shift[0];
								st_next.first_rd = 1'b1;
								st_next.sda_oe = 1'b1;
								st_next.state = icp_pkg::ST_ACK;
							end
							else
								st_next.state = icp_pkg::ST_SKIP;
						end
						else
						begin
							st_next.sda_oe = 1'b1;
							st_next.state = icp_pkg::ST_ACK;
							case (st_reg.phase)
								icp_pkg::PH_CMD:
								begin
									st_next.cmd = st_reg.shift[1:0];
									st_next.phase = icp_pkg::PH_REG;
								end
								icp_pkg::PH_REG:
								begin
									st_next.ptr = st_reg.shift[AW-1:0];
									st_next.phase = icp_pkg::PH_DATA;
								end
								default:
								begin
									if (st_reg.cmd == `ICP_CMD_WRITE)
									begin
										st_next.cfg[st_reg.ptr*8 +: 8] = st_reg.shift;
										st_next.ptr = st_reg.ptr + AW'(1);
									end
								end
							endcase
						end
					end
				end
				icp_pkg::ST_ACK:
				begin
					if (ev.scl_fall)
					begin
						if (st_reg.rnw)
						begin
							// Identity byte first, then registers from pointer
							if (st_reg.first_rd)
								st_next.shift = ID_BYTE;
							st_next.sda_oe = ~st_next.shift[7];
							st_next.bitcnt = 4'h1;
							st_next.state = icp_pkg::ST_TX;
						end
						else
						begin
							st_next.sda_oe = 1'b0;
							st_next.state = icp_pkg::ST_RX;
						end
					end
				end
				icp_pkg::ST_TX:
				begin
					if (ev.scl_fall)
					begin
						if (st_reg.bitcnt == 4'h8)
						begin
							st_next.sda_oe = 1'b0;
							st_next.state = icp_pkg::ST_TXACK;
						end
						else
						begin
							st_next.sda_oe = ~st_reg.shift[3'h7 - st_reg.bitcnt[2:0]];
							st_next.bitcnt = st_reg.bitcnt + 4'h1;
						end
					end
				end
				icp_pkg::ST_TXACK:
				begin
					if (ev.scl_rise)
					begin
						// Master nack ends the read
						if (ev.sda)
							st_next.state = icp_pkg::ST_SKIP;
						else
							st_next.state = icp_pkg::ST_ACK;
						if (!st_reg.first_rd)
							st_next.ptr = st_reg.ptr + AW'(1);
						st_next.first_rd = 1'b0;
					end
					if (st_reg.state == icp_pkg::ST_TXACK && ev.scl_rise && !ev.sda)
						st_next.shift = st_reg.first_rd ? st_reg.cfg[st_reg.ptr*8 +: 8]
							: st_reg.cfg[AW'(st_reg.ptr + AW'(1))*8 +: 8];
				end
				icp_pkg::ST_IDLE, icp_pkg::ST_SKIP:
				begin
					st_next.sda_oe = 1'b0;
				end
				default:
				begin
					st_next.state = icp_pkg::ST_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_reg <= '0;
			// Power-up restore before any ack
			st_reg.state <= icp_pkg::ST_NV;
			st_reg.nv_op <= `ICP_CMD_RESTORE;
			st_reg.restoring <= 1'b1;
		end
		else
			st_reg <= st_next;
	end
	assign o_sda_out = 1'b0;
	assign o_sda_oe = st_reg.sda_oe;
	assign o_outputs_off = st_reg.restoring;
	assign o_busy = (st_reg.state == icp_pkg::ST_NV);
	assign o_cfg = st_reg.cfg;
endmodule

// *** tb/icp_top_asserts.sv ***
// Purpose: output checks of the command port
// Assumes: bound to icp_top
// Notes: one clock domain
`timescale 1ns/1ps
module icp_top_asserts
#(
	parameter int NREGS = 128
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_scl,
	input wire logic o_sda_oe,
	input wire logic o_outputs_off,
	input wire logic o_busy,
	input wire logic [NREGS*8-1:0] o_cfg
);
	localparam int BMAX = NREGS * 5 + 8;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	property p_off; o_outputs_off |-> o_busy; endproperty
	a_off: assert property (p_off) else $error("off outside copy");
	property p_end; $fell(o_outputs_off) |-> !o_busy; endproperty
	a_end: assert property (p_end) else $error("restore end");
	property p_noack; o_busy |-> !o_sda_oe; endproperty
	a_noack: assert property (p_noack) else $error("ack while busy");
	property p_len; o_busy |-> ##[1:BMAX] !o_busy; endproperty
	a_len: assert property (p_len) else $error("copy too long");
	property p_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
	a_edge: assert property (p_edge) else $error("sda moved in high");
	property p_hold; $rose(i_scl) |=> $stable(o_sda_oe)[*4]; endproperty
	a_hold: assert property (p_hold) else $error("sda unstable");
	property p_wr; $changed(o_cfg) |-> o_busy || $past(o_busy) || !i_scl; endproperty
	a_wr: assert property (p_wr) else $error("cfg moved");
	property p_save; o_busy && !o_outputs_off |-> $stable(o_cfg); endproperty
	a_save: assert property (p_save) else $error("save touched cfg");
endmodule
bind icp_top icp_top_asserts #(.NREGS(NREGS)) u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
	.i_scl(i_scl), .o_sda_oe(o_sda_oe), .o_outputs_off(o_outputs_off), .o_busy(o_busy),
	.o_cfg(o_cfg));

// *** tb/icp_master.sv ***
// Purpose: behavioural I2C bus master
// Assumes: 16 core clocks a bit, SDA pulled up by the bench
// Notes: SCL stands high between frames
`timescale 1ns/1ps
module icp_master
(
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl = 1'h1,
	output logic o_sda = 1'h1
);
	task automatic s(input logic c, input logic d);
		o_scl <= c;
		o_sda <= d;
		repeat (4) @(posedge i_clk);
	endtask
	// Start: SDA falls while SCL stands high
	task automatic start_cond;
		s(1'h1, 1'h1);
		s(1'h1, 1'h0);
		s(1'h0, 1'h0);
		s(1'h0, 1'h0);
	endtask
	// Stop; tail lets a copy get going
	task automatic stop_cond;
		s(1'h0, 1'h0);
		s(1'h1, 1'h0);
		s(1'h1, 1'h1);
		s(1'h1, 1'h1);
	endtask
	// SDA moves only with SCL low, so no false start or stop
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
		logic [8:0] w;
		logic [8:0] v;
		w = {d, m};
		for (int i = 8; i >= 0; i--)
		begin
			s(1'h0, w[i]);
			s(1'h1, w[i]);
			v[i] = i_sda;
			s(1'h1, w[i]);
			s(1'h0, w[i]);
		end
		{r, a} = v;
	endtask
endmodule

// *** tb/icp_top_tb_top.sv ***
// Purpose: self-checking bench of the command port
// Assumes: 64 registers, so a copy outlasts an address byte
// Notes: data sits in the four lowest registers
`timescale 1ns/1ps
`include "icp_defs.svh"
module icp_top_tb_top;
	localparam int N = 64;
	localparam logic [7:0] AW = {`ICP_SLAVE_ADDR, 1'h0};
	logic i_clk = 1'h0;
	logic i_arst_n = 1'h0;
	logic scl, m_sda, oe, so, off, busy, a;
	logic [N*8-1:0] cfg;
	logic [31:0] exp, nv;
	logic [7:0] r;
	int p, fail_count = 0, checks_done = 0;
	// Open drain with pull-up: the device line only counts while enabled
	wire sda = m_sda & (~oe | so);
	icp_top #(.NREGS(N)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(so), .o_sda_oe(oe), .o_outputs_off(off), .o_busy(busy), .o_cfg(cfg));
	icp_master M (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	function automatic logic [7:0] nth(input logic [31:0] v, input int k);
		return v[k*8+:8];
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] d, input logic ack);
		M.xfer(d, 1'h1, r, a);
		chk(a, ack);
	endtask
	task automatic cmd(input logic [1:0] c);
		M.start_cond;
		wr(AW, 1'h0);
		wr({6'($urandom), c}, 1'h0);
	endtask
	task automatic idle;
		repeat (1000)
			if (busy !== 1'h0)
				@(posedge i_clk);
		chk(busy, 32'h0);
		if (busy !== 1'h0)
			end_of_test;
	endtask
	task automatic load;
		exp = $urandom;
		cmd(`ICP_CMD_WRITE);
		wr(8'h00, 1'h0);
		for (int k = 0; k < 4; k++)
			wr(nth(exp, k), 1'h0);
		M.stop_cond;
		chk(cfg[31:0], exp);
	endtask
	task automatic rd(input logic m, input logic [7:0] e);
		M.xfer(8'hFF, m, r, a);
		chk(r, e);
	endtask
	initial
		forever #5 i_clk = ~i_clk;
	initial
	begin
		void'($urandom(32'h4E5D46F6));
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'h1;
		repeat (8) @(posedge i_clk);
		chk({busy, off}, 32'h3);
		idle;
		chk(cfg[31:0], 32'h0);
		chk(so, 32'h0);
		// Foreign address must go unanswered
		M.start_cond;
		wr(AW ^ 8'h02, 1'h1);
		M.stop_cond;
		load;
		p = $urandom % 3;
		cmd(`ICP_CMD_WRITE);
		wr(8'(p), 1'h0);
		M.stop_cond;
		M.start_cond;
		wr(AW | 8'h01, 1'h0);
		rd(1'h0, `ICP_ID_BYTE);
		rd(1'h0, nth(exp, p));
		rd(1'h1, nth(exp, p + 1));
		M.stop_cond;
		nv = exp;
		cmd(`ICP_CMD_SAVE);
		M.stop_cond;
		chk({busy, off}, 32'h2);
		M.start_cond;
		wr(AW, 1'h1);
		M.stop_cond;
		idle;
		load;
		cmd(`ICP_CMD_RESTORE);
		M.stop_cond;
		chk({busy, off}, 32'h3);
		idle;
		chk(cfg[31:0], nv);
		end_of_test;
	end
endmodule
